// [design/vlan_table_write_staging.sv]
`timescale 1ns/10ps
// Functional notes
// RULE1: port table takes vid 11:0, priority 14:12
// RULE2: untagged or null-vid frames get port defaults
// RULE3: vlan disable forces port default vid
// RULE4: reset defaults vid 1, priority 0, all ports
// RULE5: software avoids vid 0 and fffh
// RULE6: bit 17 port2 member, bit 15 port1 member
// RULE7: members admitted on ingress
// RULE8: members in egress broadcast domain
// RULE9: non-members dropped unless admitted; excluded egress
// RULE10: bit 16 strips tag on hybrid port 2
// RULE11: software loads data, then writes command
// RULE12: select bit 1 port table, else vlan
// RULE13: bits 14,13,12 and vid 11:0 layout
// RULE14: staging word holds until overwritten
module vlan_table_write_staging #(
   parameter int NUM_VLANS = 16
) (
   input  wire logic        clk,
   input  wire logic        sys_rst,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   input  wire logic [15:0] reg_addr,
   input  wire logic [31:0] reg_wdata,
   output logic      [31:0] reg_rdata,
   output logic             cmd_pending,
   input  wire logic        vlan_disable,
   input  wire logic [2:0]  admit_nonmember_control,
   input  wire logic        egress_port_type_control,
   input  wire logic [1:0]  rx_port,
   input  wire logic        rx_tagged,
   input  wire logic [11:0] rx_vid,
   input  wire logic [2:0]  rx_prio,
   output logic      [11:0] class_vid,
   output logic      [2:0]  class_prio,
   output logic             class_admit,
   output logic      [2:0]  class_egress_mask,
   output logic             class_strip_port2
);
   initial
   begin
      if (NUM_VLANS < 1 || NUM_VLANS > 16)
         $error("vlan_table_write_staging: NUM_VLANS out of range");
   end

   localparam int NP = vlan_stage_pkg::num_ports;

   logic [17:0]            stage_q, stage_d;
   logic                   pend_q, pend_d;
   logic [5:0]             cmd_q, cmd_d;
   logic [NUM_VLANS*12-1:0] evid_q, evid_d;
   logic [NUM_VLANS*3-1:0]  emem_q, emem_d;
   logic [NUM_VLANS*3-1:0]  eunt_q, eunt_d;
   logic [NP*12-1:0]       pvid_q, pvid_d;
   logic [NP*3-1:0]        pprio_q, pprio_d;
   logic [31:0]            rdata_q, rdata_d;

   always_comb
   begin
      logic [3:0] idx;
      idx     = cmd_q[vlan_stage_pkg::cmd_index_lsb +: vlan_stage_pkg::cmd_index_width];
      stage_d = stage_q; // RULE14
      cmd_d   = cmd_q;
      pend_d  = 1'b0;
      evid_d  = evid_q;
      emem_d  = emem_q;
      eunt_d  = eunt_q;
      pvid_d  = pvid_q;
      pprio_d = pprio_q;
      rdata_d = rdata_q;
      if (reg_wr && reg_addr == vlan_stage_pkg::stage_offset)
         stage_d = reg_wdata[17:0];
      else if (reg_wr && reg_addr == vlan_stage_pkg::command_offset) // RULE11
      begin
         cmd_d  = reg_wdata[5:0];
         pend_d = 1'b1;
      end
      if (pend_q && !cmd_q[vlan_stage_pkg::cmd_read_bit])
      begin
         if (cmd_q[vlan_stage_pkg::cmd_table_bit]) // RULE12
         begin
            if (32'(idx) < NP)
            begin
               pvid_d[idx*12 +: 12] = stage_q[vlan_stage_pkg::vid_lsb +: 12]; // RULE1
               pprio_d[idx*3 +: 3]  = stage_q[vlan_stage_pkg::prio_lsb +: 3]; // RULE1
            end
         end
         else if (32'(idx) < NUM_VLANS)
         begin
            evid_d[idx*12 +: 12] = stage_q[vlan_stage_pkg::vid_lsb +: 12]; // RULE13
            emem_d[idx*3 +: 3]   = {stage_q[vlan_stage_pkg::member2_bit],
                                    stage_q[vlan_stage_pkg::member1_bit],
                                    stage_q[vlan_stage_pkg::member0_bit]}; // RULE6 RULE13
            eunt_d[idx*3 +: 3]   = {stage_q[vlan_stage_pkg::untag2_bit],
                                    stage_q[vlan_stage_pkg::untag1_bit],
                                    stage_q[vlan_stage_pkg::untag0_bit]}; // RULE10 RULE13
         end
      end
      if (reg_rd && reg_addr == vlan_stage_pkg::stage_offset)
         rdata_d = {14'h0000, stage_q};
      else if (reg_rd && reg_addr == vlan_stage_pkg::command_offset)
         rdata_d = {26'h0000000, cmd_q};
      else if (reg_rd)
         rdata_d = 32'h00000000;
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         stage_q <= vlan_stage_pkg::stage_reset;
         cmd_q   <= 6'h00;
         pend_q  <= 1'b0;
         evid_q  <= '0;
         emem_q  <= '0;
         eunt_q  <= '0;
         pvid_q  <= {NP{vlan_stage_pkg::pvid_reset}}; // RULE4
         pprio_q <= {NP{vlan_stage_pkg::prio_reset}}; // RULE4
         rdata_q <= 32'h00000000;
      end
      else
      begin
         stage_q <= stage_d;
         cmd_q   <= cmd_d;
         pend_q  <= pend_d;
         evid_q  <= evid_d;
         emem_q  <= emem_d;
         eunt_q  <= eunt_d;
         pvid_q  <= pvid_d;
         pprio_q <= pprio_d;
         rdata_q <= rdata_d;
      end
   end

   assign reg_rdata   = rdata_q;
   assign cmd_pending = pend_q;

   vlan_ingress_lookup #(
      .NUM_VLANS (NUM_VLANS),
      .NUM_PORTS (NP)
   ) u_lookup (
      .entry_vid                (evid_q),
      .entry_member             (emem_q),
      .entry_untag              (eunt_q),
      .port_vid                 (pvid_q),
      .port_prio                (pprio_q),
      .rx_port                  (rx_port),
      .rx_tagged                (rx_tagged),
      .rx_vid                   (rx_vid),
      .rx_prio                  (rx_prio),
      .vlan_disable             (vlan_disable),
      .admit_nonmember_control  (admit_nonmember_control),
      .egress_port_type_control (egress_port_type_control),
      .class_vid                (class_vid),
      .class_prio               (class_prio),
      .class_admit              (class_admit),
      .class_egress_mask        (class_egress_mask),
      .class_strip_port2        (class_strip_port2)
   );
endmodule

// [design/vlan_stage_pkg.sv]
package vlan_stage_pkg;
   localparam logic [15:0] stage_offset     = 16'h180c;
   localparam logic [15:0] command_offset   = 16'h180b;
   localparam int          stage_width      = 18;
   localparam int          vid_lsb          = 0;
   localparam int          vid_width        = 12;
   localparam int          prio_lsb         = 12;
   localparam int          prio_width       = 3;
   localparam int          untag0_bit       = 12;
   localparam int          member0_bit      = 13;
   localparam int          untag1_bit       = 14;
   localparam int          member1_bit      = 15;
   localparam int          untag2_bit       = 16;
   localparam int          member2_bit      = 17;
   localparam int          cmd_index_lsb    = 0;
   localparam int          cmd_index_width  = 4;
   localparam int          cmd_table_bit    = 4;
   localparam int          cmd_read_bit     = 5;
   localparam int          num_ports        = 3;
   localparam int          num_vlans        = 16;
   localparam logic [11:0] pvid_reset       = 12'h001;
   localparam logic [2:0]  prio_reset       = 3'h0;
   localparam logic [17:0] stage_reset      = 18'h00000;
   localparam logic [11:0] null_vid         = 12'h000;
endpackage

// [design/vlan_ingress_lookup.sv]
`timescale 1ns/10ps
// classifies one received frame against the tables
module vlan_ingress_lookup #(
   parameter int NUM_VLANS = 16,
   parameter int NUM_PORTS = 3
) (
   input  wire logic [NUM_VLANS*12-1:0] entry_vid,
   input  wire logic [NUM_VLANS*3-1:0]  entry_member,
   input  wire logic [NUM_VLANS*3-1:0]  entry_untag,
   input  wire logic [NUM_PORTS*12-1:0] port_vid,
   input  wire logic [NUM_PORTS*3-1:0]  port_prio,
   input  wire logic [1:0]              rx_port,
   input  wire logic                    rx_tagged,
   input  wire logic [11:0]             rx_vid,
   input  wire logic [2:0]              rx_prio,
   input  wire logic                    vlan_disable,
   input  wire logic [NUM_PORTS-1:0]    admit_nonmember_control,
   input  wire logic                    egress_port_type_control,
   output logic      [11:0]             class_vid,
   output logic      [2:0]              class_prio,
   output logic                         class_admit,
   output logic      [NUM_PORTS-1:0]    class_egress_mask,
   output logic                         class_strip_port2
);
   initial
   begin
      if (NUM_PORTS != 3 || NUM_VLANS < 1)
         $error("vlan_ingress_lookup: unsupported size");
   end

   logic        hit;
   logic [2:0]  mem;
   logic [2:0]  unt;

   always_comb
   begin
      hit = 1'b0;
      mem = 3'h0;
      unt = 3'h0;
      if (!rx_tagged || rx_vid == vlan_stage_pkg::null_vid || vlan_disable) // RULE2 RULE3
         class_vid = port_vid[rx_port*12 +: 12];
      else
         class_vid = rx_vid;
      // disable swaps only the vid; a valid tag keeps its own priority
      if (!rx_tagged || rx_vid == vlan_stage_pkg::null_vid) // RULE2
         class_prio = port_prio[rx_port*3 +: 3];
      else
         class_prio = rx_prio;
      for (int i = 0; i < NUM_VLANS; i++)
      begin
         if (!hit && entry_vid[i*12 +: 12] != vlan_stage_pkg::null_vid
             && entry_vid[i*12 +: 12] == class_vid)
         begin
            hit = 1'b1;
            mem = entry_member[i*3 +: 3];
            unt = entry_untag[i*3 +: 3];
         end
      end
      class_admit       = vlan_disable || mem[rx_port] || admit_nonmember_control[rx_port]; // RULE7 RULE9
      class_egress_mask = vlan_disable ? 3'h7 : mem; // RULE8 RULE9
      class_strip_port2 = unt[2] && egress_port_type_control && mem[2]; // RULE10
   end
endmodule

// [bench/vlan_stage_checker_properties.sv]
`timescale 1ns/10ps
module vlan_stage_checker (
   input logic        clk,
   input logic        sys_rst,
   input logic        reg_wr,
   input logic        reg_rd,
   input logic [15:0] reg_addr,
   input logic [31:0] reg_wdata,
   input logic [31:0] reg_rdata,
   input logic        cmd_pending,
   input logic        vlan_disable,
   input logic [2:0]  admit_nonmember_control,
   input logic        egress_port_type_control,
   input logic [1:0]  rx_port,
   input logic        class_admit,
   input logic [2:0]  class_egress_mask,
   input logic        class_strip_port2
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   chk_cmd_pending: assert property (reg_wr && reg_addr == 16'h180b |=> cmd_pending)
      else $error("no pending after command write");
   chk_pending_pulse: assert property (!(reg_wr && reg_addr == 16'h180b) |=> !cmd_pending)
      else $error("pending without command write");
   chk_stage_readback: assert property (reg_wr && reg_addr == 16'h180c ##1 !reg_wr
      ##1 reg_rd && reg_addr == 16'h180c |=> reg_rdata == {14'h0, $past(reg_wdata[17:0], 3)})
      else $error("staging readback wrong");
   chk_rdata_hold: assert property (!reg_rd |=> $stable(reg_rdata))
      else $error("read data changed without read");
   chk_disable_flood: assert property (vlan_disable |-> class_admit && class_egress_mask == 3'h7)
      else $error("disabled vlan not flooded");
   chk_strip_hybrid: assert property (class_strip_port2
      |-> egress_port_type_control && class_egress_mask[2]) else $error("strip off hybrid");
   chk_nonmember_drop: assert property (!vlan_disable && rx_port < 2'h3 && class_admit
      |-> class_egress_mask[rx_port] || admit_nonmember_control[rx_port]) else $error("bad admit");
   chk_member_admit: assert property (!vlan_disable && rx_port < 2'h3
      && class_egress_mask[rx_port] |-> class_admit) else $error("member dropped");
endmodule

// [bench/tb_vlan_table_write_staging.sv]
`timescale 1ns/10ps
module tb_vlan_table_write_staging;
   logic        clk, sys_rst, reg_wr, reg_rd, cmd_pending;
   logic [15:0] reg_addr;
   logic [31:0] reg_wdata, reg_rdata;
   logic [23:0] ctl;
   logic [19:0] cls;
   int          err_total = 0, check_count = 0;
   vlan_table_write_staging #(.NUM_VLANS(16)) dut (.clk, .sys_rst, .reg_wr, .reg_rd, .reg_addr,
      .reg_wdata, .reg_rdata, .cmd_pending, .vlan_disable(ctl[18]), .rx_port(ctl[17:16]),
      .admit_nonmember_control(ctl[21:19]), .egress_port_type_control(ctl[22]), .rx_tagged(ctl[15]),
      .rx_prio(ctl[14:12]), .rx_vid(ctl[11:0]), .class_vid(cls[19:8]), .class_prio(cls[7:5]),
      .class_admit(cls[4]), .class_egress_mask(cls[3:1]), .class_strip_port2(cls[0]));
   initial forever #50 clk = ~clk;
   task automatic check(input string n, input logic [31:0] e, input logic [31:0] g);
      check_count++;
      if (g !== e)
      begin
         err_total++;
         $display("unexpected %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic summarize();
      $display("checks %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic bus(input logic w, input logic [15:0] a, input logic [31:0] d);
      @(posedge clk);
      {reg_wr, reg_rd, reg_addr, reg_wdata} <= {w, ~w, a, d};
      @(posedge clk);
      {reg_wr, reg_rd} <= 2'h0;
      if (!w)
         #1 check("reg_rdata", d, reg_rdata);
   endtask
   task automatic cmd(input logic [5:0] c);
      bus(1'h1, 16'h180b, {26'h0, c});
      #1 check("cmd_pending", 32'h1, {31'h0, cmd_pending});
      @(posedge clk);
   endtask
   task automatic frame(input logic [23:0] f, input logic [19:0] e);
      @(posedge clk);
      ctl <= f;
      #1 check("class", {12'h0, e}, {12'h0, cls});
   endtask
   initial
   begin
      repeat (3000) @(posedge clk);
      err_total++;
      summarize();
   end
   initial
   begin
      {clk, sys_rst, reg_wr, reg_rd, reg_addr, reg_wdata, ctl} = {2'h1, 2'h0, 16'h0, 32'h0, 24'h0};
      repeat (16) @(posedge clk);
      sys_rst <= 1'h0;
      for (int i = 0; i < 3; i++)
         frame({6'h0, i[1:0], 16'h0}, 20'h00100);
      $display("reset defaults done");
      bus(1'h1, 16'h180c, 32'hffffd123);
      bus(1'h0, 16'h180c, 32'h0003d123);
      cmd(6'h11);
      frame(24'h010000, 20'h123a0);
      frame(24'h01a000, 20'h123a0);
      frame(24'h05a055, 20'h1235e);
      cmd(6'h12);
      frame(24'h020000, 20'h123a0);
      $display("port defaults done");
      bus(1'h1, 16'h180c, 32'h00038055);
      cmd(6'h00);
      bus(1'h1, 16'h180c, 32'h000070aa);
      cmd(6'h05);
      frame(24'h41b055, 20'h0557d);
      frame(24'h01b055, 20'h0557c);
      frame(24'h00b055, 20'h0556c);
      frame(24'h08b055, 20'h0557c);
      frame(24'h40b0aa, 20'h0aa72);
      cmd(6'h31);
      cmd(6'h13);
      frame(24'h010000, 20'h123a0);
      $display("vlan entries done");
      bus(1'h0, 16'h1800, 32'h0);
      bus(1'h0, 16'h180c, 32'h000070aa);
      $display("register map done");
      summarize();
   end
endmodule
bind vlan_table_write_staging vlan_stage_checker chk (.clk, .sys_rst, .reg_wr, .reg_rd, .reg_addr,
   .reg_wdata, .reg_rdata, .cmd_pending, .vlan_disable, .admit_nonmember_control,
   .egress_port_type_control, .rx_port, .class_admit, .class_egress_mask, .class_strip_port2);
